// ===== src/bms_sequencer.sv
// Summary of operation
// - Mode bit 0: charge counter runs with current sensing, voltage gauge alongside.
// - Mode bit 1: voltage gauge only, no current conversions, counter unused.
// - Mixed mode: current back to back, one voltage per 4 s, temperature per 16 s.
// - Voltage-only mode: voltage every 4 s, temperature every 16 s, nothing between.
// - A voltage conversion lasts 8192 time-base periods, 250 ms.
// - Each voltage result is stored in the voltage result register.
// - Temperature takes 8192 periods; result goes to the temperature register.
// - Current conversion integrates 500 ms and yields a 14-bit result.
// - Current result is two's complement, sign shows charge or discharge.
// - Each finished current conversion adds to accumulator, bumps 16-bit count.
// - Current register updated only by the conversion nearest the voltage one.
// - Charge scale value scales charge to percent; resets to 395.
// - Charge scale value is a 16-bit unsigned integer.
// - Counter idle while mode bit set; reset sets mode bit to 1.
// - Writing the charge level register stores that value and restarts counting from zero.
// - Voltage model value is 12-bit unsigned, resets to 321.
// - Rest voltage register holds the model's current rest voltage estimate.
// - A changed voltage reading updates rest voltage and charge estimates.
// - One shared converter: at most one conversion at a time.
// - Mode may change at run time; schedule follows, charge tracking kept.
module bms_sequencer #(
  parameter int unsigned TB_DIV = bms_pkg::TB_DIV,
  parameter int unsigned TB_PER_MEAS = bms_pkg::TB_PER_MEAS,
  parameter int unsigned VT_CONV_TB = bms_pkg::VT_CONV_TB,
  parameter int unsigned CUR_CONV_TB = bms_pkg::CUR_CONV_TB
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Decoded register access
  input wire bms_pkg::bms_reg_req_t reg_req_i,
  output logic [bms_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Shared converter
  input wire logic [bms_pkg::DATA_W-1:0] adc_result_i,
  output bms_pkg::bms_conv_t conv_state_o,
  output logic conv_take_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync;
  logic rst_n;

  // Two stages so the release is clean against the clock
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************************************
  // Time base and measurement intervals
  // ****************************************************************
  logic [11:0] div_cnt, next_div_cnt;
  logic [17:0] meas_cnt, next_meas_cnt;
  logic [1:0] temp_cnt, next_temp_cnt;
  logic tick, next_tick;
  logic meas_evt, next_meas_evt;
  logic temp_evt, next_temp_evt;

  // One enable pulse per time-base period, intervals counted in periods
  always_comb begin
    next_div_cnt = div_cnt + 12'h001;
    next_tick = 1'b0;
    next_meas_cnt = meas_cnt;
    next_temp_cnt = temp_cnt;
    next_meas_evt = 1'b0;
    next_temp_evt = 1'b0;
    if (div_cnt == 12'(TB_DIV - 1)) begin
      next_div_cnt = 12'h000;
      next_tick = 1'b1;
    end
    if (tick) begin
      next_meas_cnt = meas_cnt + 18'h00001;
      if (meas_cnt == 18'(TB_PER_MEAS - 1)) begin
        next_meas_cnt = 18'h00000;
        next_meas_evt = 1'b1;
        next_temp_cnt = temp_cnt + 2'h1;
        if (temp_cnt == 2'(bms_pkg::TEMP_EVERY - 1)) begin
          next_temp_cnt = 2'h0;
          next_temp_evt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      meas_cnt <= 18'h00000;
      temp_cnt <= 2'h0;
      tick <= 1'b0;
      meas_evt <= 1'b0;
      temp_evt <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      meas_cnt <= next_meas_cnt;
      temp_cnt <= next_temp_cnt;
      tick <= next_tick;
      meas_evt <= next_meas_evt;
      temp_evt <= next_temp_evt;
    end
  end

  // ****************************************************************
  // Conversion scheduler, results and registers
  // ****************************************************************
  bms_pkg::bms_conv_t state, next_state;
  logic [14:0] conv_cnt, next_conv_cnt;
  logic [14:0] conv_last;
  logic conv_end;
  logic pend_v, next_pend_v;
  logic pend_t, next_pend_t;
  logic mode, next_mode;
  logic [bms_pkg::DATA_W-1:0] charge_level, next_charge_level;
  logic [bms_pkg::VOLT_W-1:0] volt_res, next_volt_res;
  logic [bms_pkg::CUR_W-1:0] cur_res, next_cur_res;
  logic [bms_pkg::TEMP_W-1:0] temp_res, next_temp_res;
  logic [bms_pkg::ACC_W-1:0] acc, next_acc;
  logic [15:0] conv_count, next_conv_count;
  logic [bms_pkg::DATA_W-1:0] cc_cnf, next_cc_cnf;
  logic [bms_pkg::VM_CNF_W-1:0] vm_cnf, next_vm_cnf;
  logic [bms_pkg::VOLT_W-1:0] rest_est, next_rest_est;
  logic [7:0] vm_level, next_vm_level;
  logic [bms_pkg::DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_take;
  logic signed [12:0] vm_diff, vm_step;
  logic [bms_pkg::VOLT_W-1:0] new_volt;

  // Conversion length depends on kind: current integrates twice as long
  assign conv_last = (state == bms_pkg::BMS_CURR) ? 15'(CUR_CONV_TB - 1)
                                                  : 15'(VT_CONV_TB - 1);
  assign conv_end = tick && (conv_cnt == conv_last);
  assign new_volt = adc_result_i[bms_pkg::VOLT_W-1:0];
  // First-order tracking of the rest voltage toward each new reading
  assign vm_diff = $signed({1'b0, new_volt}) - $signed({1'b0, rest_est});
  assign vm_step = vm_diff >>> bms_pkg::VM_SHIFT;

  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_pend_v = pend_v;
    next_pend_t = pend_t;
    next_mode = mode;
    next_charge_level = charge_level;
    next_volt_res = volt_res;
    next_cur_res = cur_res;
    next_temp_res = temp_res;
    next_acc = acc;
    next_conv_count = conv_count;
    next_cc_cnf = cc_cnf;
    next_vm_cnf = vm_cnf;
    next_rest_est = rest_est;
    next_vm_level = vm_level;
    next_take = 1'b0;
    next_rvalid = 1'b0;
    next_rdata = reg_rdata_o;
    if (tick && (state != bms_pkg::BMS_IDLE)) begin
      next_conv_cnt = conv_cnt + 15'h0001;
    end
    // Only one kind runs at a time; voltage beats temperature beats current
    case (state)
      bms_pkg::BMS_IDLE: begin
        next_conv_cnt = 15'h0000;
        if (pend_v) begin
          next_state = bms_pkg::BMS_VOLT;
          next_pend_v = 1'b0;
        end else if (pend_t) begin
          next_state = bms_pkg::BMS_TEMP;
          next_pend_t = 1'b0;
        end else if (!mode) begin
          next_state = bms_pkg::BMS_CURR;
        end
      end
      bms_pkg::BMS_VOLT: begin
        if (conv_end) begin
          next_state = bms_pkg::BMS_IDLE;
          next_take = 1'b1;
          next_volt_res = new_volt;
          // Model only moves when the reading actually changed
          if (new_volt != volt_res) begin
            next_rest_est = 12'($signed({1'b0, rest_est}) + vm_step);
            next_vm_level = next_rest_est[bms_pkg::VOLT_W-1:4];
          end
        end
      end
      bms_pkg::BMS_TEMP: begin
        if (conv_end) begin
          next_state = bms_pkg::BMS_IDLE;
          next_take = 1'b1;
          next_temp_res = adc_result_i[bms_pkg::TEMP_W-1:0];
        end
      end
      bms_pkg::BMS_CURR: begin
        // Leaving mixed mode abandons the running integration unused
        if (mode) begin
          next_state = bms_pkg::BMS_IDLE;
        end else if (conv_end) begin
          next_state = bms_pkg::BMS_IDLE;
          next_take = 1'b1;
          next_acc = acc + {{(bms_pkg::ACC_W - bms_pkg::CUR_W){adc_result_i[bms_pkg::CUR_W-1]}},
                            adc_result_i[bms_pkg::CUR_W-1:0]};
          next_conv_count = conv_count + 16'h0001;
          // A pending voltage run means this is the one nearest to it
          if (pend_v) begin
            next_cur_res = adc_result_i[bms_pkg::CUR_W-1:0];
          end
        end
      end
      default: begin
        next_state = bms_pkg::BMS_IDLE;
      end
    endcase
    // Interval events are set after the clear so a coinciding one survives
    if (meas_evt) begin
      next_pend_v = 1'b1;
    end
    if (temp_evt) begin
      next_pend_t = 1'b1;
    end
    // Host writes; a charge level write restarts counting and wins
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        bms_pkg::REG_MODE: next_mode = reg_req_i.wdata[0];
        bms_pkg::REG_CHARGE_LEVEL: begin
          next_charge_level = reg_req_i.wdata;
          next_acc = '0;
          next_conv_count = 16'h0000;
        end
        bms_pkg::REG_CHARGE_SCALE: next_cc_cnf = reg_req_i.wdata;
        bms_pkg::REG_VM_CONFIG: next_vm_cnf = reg_req_i.wdata[bms_pkg::VM_CNF_W-1:0];
        default: begin
        end
      endcase
    end
    // Reads answer one cycle later; unmapped indices read zero
    if (reg_req_i.rd) begin
      next_rvalid = 1'b1;
      case (reg_req_i.addr)
        bms_pkg::REG_MODE: next_rdata = {15'h0000, mode};
        bms_pkg::REG_CHARGE_LEVEL: next_rdata = charge_level;
        bms_pkg::REG_VOLTAGE: next_rdata = {4'h0, volt_res};
        bms_pkg::REG_CURRENT: next_rdata = {{2{cur_res[bms_pkg::CUR_W-1]}}, cur_res};
        bms_pkg::REG_TEMPERATURE: next_rdata = {8'h00, temp_res};
        bms_pkg::REG_ACC_LO: next_rdata = acc[15:0];
        bms_pkg::REG_ACC_HI: next_rdata = acc[31:16];
        bms_pkg::REG_CONV_COUNT: next_rdata = conv_count;
        bms_pkg::REG_CHARGE_SCALE: next_rdata = cc_cnf;
        bms_pkg::REG_VM_CONFIG: next_rdata = {4'h0, vm_cnf};
        bms_pkg::REG_REST_VOLT: next_rdata = {4'h0, rest_est};
        bms_pkg::REG_VM_LEVEL: next_rdata = {8'h00, vm_level};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= bms_pkg::BMS_IDLE;
      conv_cnt <= 15'h0000;
      pend_v <= 1'b0;
      pend_t <= 1'b0;
      mode <= bms_pkg::MODE_RST;
      charge_level <= 16'h0000;
      volt_res <= 12'h000;
      cur_res <= 14'h0000;
      temp_res <= 8'h00;
      acc <= 32'h00000000;
      conv_count <= 16'h0000;
      cc_cnf <= bms_pkg::CC_CNF_RST;
      vm_cnf <= bms_pkg::VM_CNF_RST;
      rest_est <= 12'h000;
      vm_level <= 8'h00;
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
      conv_take_o <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      pend_v <= next_pend_v;
      pend_t <= next_pend_t;
      mode <= next_mode;
      charge_level <= next_charge_level;
      volt_res <= next_volt_res;
      cur_res <= next_cur_res;
      temp_res <= next_temp_res;
      acc <= next_acc;
      conv_count <= next_conv_count;
      cc_cnf <= next_cc_cnf;
      vm_cnf <= next_vm_cnf;
      rest_est <= next_rest_est;
      vm_level <= next_vm_level;
      reg_rdata_o <= next_rdata;
      reg_rvalid_o <= next_rvalid;
      conv_take_o <= next_take;
    end
  end

  // Converter kind straight from the state flops
  assign conv_state_o = state;

endmodule : bms_sequencer

// ===== src/bms_pkg.sv
package bms_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TB_HZ = 32768;
  localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;
  localparam int unsigned MEAS_PERIOD_S = 4;
  localparam int unsigned TEMP_PERIOD_S = 16;
  localparam int unsigned TEMP_EVERY = TEMP_PERIOD_S / MEAS_PERIOD_S;
  localparam int unsigned TB_PER_MEAS = TB_HZ * MEAS_PERIOD_S;
  localparam int unsigned VT_CONV_TB = 8192;
  localparam int unsigned CUR_CONV_MS = 500;
  localparam int unsigned CUR_CONV_TB = TB_HZ * CUR_CONV_MS / 1000;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CUR_W = 14;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned VOLT_W = 12;
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned VM_CNF_W = 12;
  localparam int unsigned VM_SHIFT = 3;

  // ****************************************************************
  // Register indices and reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CHARGE_LEVEL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_VOLTAGE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CURRENT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_TEMPERATURE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ACC_LO = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ACC_HI = 4'h6;
  localparam logic [ADDR_W-1:0] REG_CONV_COUNT = 4'h7;
  localparam logic [ADDR_W-1:0] REG_CHARGE_SCALE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_VM_CONFIG = 4'h9;
  localparam logic [ADDR_W-1:0] REG_REST_VOLT = 4'hA;
  localparam logic [ADDR_W-1:0] REG_VM_LEVEL = 4'hB;
  localparam logic MODE_RST = 1'b1;
  localparam logic [DATA_W-1:0] CC_CNF_RST = 16'h018B;
  localparam logic [VM_CNF_W-1:0] VM_CNF_RST = 12'h141;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    BMS_IDLE = 4'h1,
    BMS_VOLT = 4'h2,
    BMS_TEMP = 4'h4,
    BMS_CURR = 4'h8
  } bms_conv_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bms_reg_req_t;

endpackage : bms_pkg

// ===== sim/bms_seq_asserts.sv
// ****
// Sequencer checker
// ****
module bms_seq_asserts #(
  parameter int unsigned TB_DIV = bms_pkg::TB_DIV,
  parameter int unsigned TB_PER_MEAS = bms_pkg::TB_PER_MEAS,
  parameter int unsigned VT_CONV_TB = bms_pkg::VT_CONV_TB,
  parameter int unsigned CUR_CONV_TB = bms_pkg::CUR_CONV_TB
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Register port
  input wire bms_pkg::bms_reg_req_t reg_req_i,
  input wire logic [bms_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Converter
  input wire logic [bms_pkg::DATA_W-1:0] adc_result_i,
  input wire bms_pkg::bms_conv_t conv_state_o,
  input wire logic conv_take_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Tick phase makes lengths vary by up to one tick
  localparam int VT_LO = (VT_CONV_TB - 1) * TB_DIV;
  localparam int VT_HI = VT_CONV_TB * TB_DIV + 1;
  localparam int CU_LO = (CUR_CONV_TB - 1) * TB_DIV;
  localparam int CU_HI = CUR_CONV_TB * TB_DIV + 1;
  localparam int GAP_LO = TB_PER_MEAS * TB_DIV - CU_HI - 4;
  localparam int GAP_HI = TB_PER_MEAS * TB_DIV + CU_HI + 8;
  bms_pkg::bms_conv_t prev_st;
  // Wide enough for full-length conversions and intervals at the default rates
  logic [31:0] run_cnt;
  logic [31:0] vgap;
  logic mode_q;
  logic seen_v;
  wire v_start = conv_state_o == bms_pkg::BMS_VOLT && prev_st != bms_pkg::BMS_VOLT;
  // Run length, voltage spacing and a shadow of the mode bit
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_st <= bms_pkg::BMS_IDLE;
      run_cnt <= 32'h00000000;
      vgap <= 32'h00000000;
      mode_q <= 1'b1;
      seen_v <= 1'b0;
    end else begin
      prev_st <= conv_state_o;
      run_cnt <= (conv_state_o != prev_st) ? 32'h00000001 : run_cnt + 32'h00000001;
      vgap <= v_start ? 32'h00000000 : vgap + 32'h00000001;
      seen_v <= seen_v | v_start;
      if (reg_req_i.wr && reg_req_i.addr == bms_pkg::REG_MODE) begin
        mode_q <= reg_req_i.wdata[0];
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  onehot_state_a: assert property ($onehot(conv_state_o))
    else $error("conversion state not one-hot");
  single_conv_a: assert property ((prev_st != bms_pkg::BMS_IDLE &&
    conv_state_o != bms_pkg::BMS_IDLE) |-> conv_state_o == prev_st)
    else $error("conversion kind changed without idle");
  volt_length_a: assert property ((prev_st == bms_pkg::BMS_VOLT &&
    conv_state_o != bms_pkg::BMS_VOLT) |-> conv_take_o && run_cnt inside {[VT_LO:VT_HI]})
    else $error("voltage conversion length wrong");
  temp_length_a: assert property ((prev_st == bms_pkg::BMS_TEMP &&
    conv_state_o != bms_pkg::BMS_TEMP) |-> conv_take_o && run_cnt inside {[VT_LO:VT_HI]})
    else $error("temperature conversion length wrong");
  cur_length_a: assert property ((prev_st == bms_pkg::BMS_CURR && conv_take_o)
    |-> run_cnt inside {[CU_LO:CU_HI]}) else $error("current conversion length wrong");
  take_pulse_a: assert property (conv_take_o |-> prev_st != bms_pkg::BMS_IDLE &&
    conv_state_o == bms_pkg::BMS_IDLE ##1 !conv_take_o) else $error("bad take pulse");
  no_curr_gauge_mode_select_a: assert property ((mode_q && $past(mode_q) && $past(mode_q, 2))
    |-> conv_state_o != bms_pkg::BMS_CURR) else $error("current conversion in mode 1");
  curr_restart_a: assert property ((conv_state_o == bms_pkg::BMS_IDLE && !mode_q &&
    !$past(mode_q)) |=> (mode_q || conv_state_o != bms_pkg::BMS_IDLE))
    else $error("mixed mode converter left idle");
  volt_due_a: assert property (vgap <= GAP_HI)
    else $error("voltage conversion overdue");
  volt_spacing_a: assert property ((v_start && seen_v) |-> vgap >= GAP_LO)
    else $error("voltage conversions too close");
  read_answer_a: assert property (reg_rvalid_o == $past(reg_req_i.rd))
    else $error("read answer timing wrong");
  cover property (v_start);
  cover property (conv_state_o == bms_pkg::BMS_TEMP && prev_st != bms_pkg::BMS_TEMP);
  cover property (prev_st == bms_pkg::BMS_CURR && conv_take_o);
endmodule : bms_seq_asserts
bind bms_sequencer bms_seq_asserts #(.TB_DIV(TB_DIV), .TB_PER_MEAS(TB_PER_MEAS),
  .VT_CONV_TB(VT_CONV_TB), .CUR_CONV_TB(CUR_CONV_TB)) bms_seq_asserts_inst (
  .clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .adc_result_i(adc_result_i), .conv_state_o(conv_state_o),
  .conv_take_o(conv_take_o));

// ===== sim/bms_adc_model.sv
// ****
// Converter model
// ****
module bms_adc_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Converter side
  input wire bms_pkg::bms_conv_t conv_state_o,
  output logic [bms_pkg::DATA_W-1:0] adc_result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] idle_pat;
  // Toggles while idle so a result sampled out of turn never looks valid
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_pat <= 16'h5A5A;
    end else begin
      idle_pat <= ~idle_pat;
    end
  end
  // One result per conversion kind
  always_comb begin
    case (conv_state_o)
      bms_pkg::BMS_VOLT: adc_result_o = 16'h0400;
      bms_pkg::BMS_TEMP: adc_result_o = 16'h0019;
      bms_pkg::BMS_CURR: adc_result_o = 16'h3FFD;
      default: adc_result_o = idle_pat;
    endcase
  end
endmodule : bms_adc_model

// ===== sim/bms_sequencer_tb.sv
module bms_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i;
  logic rstn_i;
  bms_pkg::bms_reg_req_t req;
  logic [15:0] rdata;
  logic [15:0] adc;
  logic rvalid;
  logic take;
  bms_pkg::bms_conv_t st;
  int error_cnt;
  int n_compared;
  logic [15:0] v;
  // Counts shortened so a run stays a few thousand cycles
  bms_sequencer #(.TB_DIV(4), .TB_PER_MEAS(64), .VT_CONV_TB(8), .CUR_CONV_TB(16))
    bms_sequencer_inst (.clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .adc_result_i(adc), .conv_state_o(st),
    .conv_take_o(take));
  bms_adc_model bms_adc_model_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .conv_state_o(st), .adc_result_o(adc));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task summarize;
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Requests launch on a falling edge and are taken on the next rising edge
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clock_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clock_i);
    req.wr = 1'b0;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [15:0] e);
    @(negedge clock_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clock_i);
    req.rd = 1'b0;
    chk({15'h0000, rvalid}, 16'h0001);
    v = rdata;
    chk(v, e);
  endtask : rdc
  // Waits for the end of the next conversion of one kind
  task wait_take(input bms_pkg::bms_conv_t k);
    bms_pkg::bms_conv_t seen;
    int i;
    seen = bms_pkg::BMS_IDLE;
    for (i = 0; i < 3000; i++) begin
      @(negedge clock_i);
      if (take === 1'b1 && seen == k) break;
      if (st != bms_pkg::BMS_IDLE) seen = st;
    end
    if (i == 3000) begin
      error_cnt++;
      $display("[FAIL] %0t conversion did not finish", $time);
    end
  endtask : wait_take
  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    rstn_i = 1'b0;
    req = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clock_i);
    rdc(bms_pkg::REG_MODE, 16'h0001);
    rdc(bms_pkg::REG_CHARGE_SCALE, 16'h018B);
    rdc(bms_pkg::REG_VM_CONFIG, 16'h0141);
    rdc(4'hF, 16'h0000);
    wr(bms_pkg::REG_CHARGE_SCALE, 16'hFFFF);
    rdc(bms_pkg::REG_CHARGE_SCALE, 16'hFFFF);
    wr(bms_pkg::REG_VM_CONFIG, 16'hFFFF);
    rdc(bms_pkg::REG_VM_CONFIG, 16'h0FFF);
    wait_take(bms_pkg::BMS_VOLT);
    rdc(bms_pkg::REG_VOLTAGE, 16'h0400);
    rdc(bms_pkg::REG_REST_VOLT, 16'h0080);
    rdc(bms_pkg::REG_VM_LEVEL, 16'h0008);
    // Same reading again must leave the estimate alone
    wait_take(bms_pkg::BMS_VOLT);
    rdc(bms_pkg::REG_REST_VOLT, 16'h0080);
    rdc(bms_pkg::REG_CONV_COUNT, 16'h0000);
    wait_take(bms_pkg::BMS_TEMP);
    rdc(bms_pkg::REG_TEMPERATURE, 16'h0019);
    wr(bms_pkg::REG_MODE, 16'h0000);
    // First current result lands long before the next voltage run: not published
    wait_take(bms_pkg::BMS_CURR);
    rdc(bms_pkg::REG_CURRENT, 16'h0000);
    wait_take(bms_pkg::BMS_VOLT);
    rdc(bms_pkg::REG_CURRENT, 16'hFFFD);
    wait_take(bms_pkg::BMS_CURR);
    wr(bms_pkg::REG_CHARGE_LEVEL, 16'h0032);
    rdc(bms_pkg::REG_CONV_COUNT, 16'h0000);
    rdc(bms_pkg::REG_CHARGE_LEVEL, 16'h0032);
    repeat (3) wait_take(bms_pkg::BMS_CURR);
    rdc(bms_pkg::REG_CONV_COUNT, 16'h0003);
    rdc(bms_pkg::REG_ACC_LO, 16'hFFF7);
    rdc(bms_pkg::REG_ACC_HI, 16'hFFFF);
    // Back to voltage-only; totals must survive and stop growing
    wr(bms_pkg::REG_MODE, 16'h0001);
    repeat (600) @(negedge clock_i);
    rdc(bms_pkg::REG_CONV_COUNT, 16'h0003);
    rdc(bms_pkg::REG_ACC_LO, 16'hFFF7);
    rdc(bms_pkg::REG_CHARGE_LEVEL, 16'h0032);
    rdc(bms_pkg::REG_MODE, 16'h0001);
    summarize;
  end
endmodule : bms_sequencer_tb
